// >>> rtl/sdcr_consts.svh
// Constants of the SDRAM configuration and refresh block.
// Assumes inclusion from the refresh and top design modules only.
`ifndef SDCR_CONSTS_SVH
`define SDCR_CONSTS_SVH
`define SDCR_CFG_OFFSET 8'h20
`define SDCR_UPORG_MSB 29
`define SDCR_UPORG_LSB 28
`define SDCR_CLKDIS_BIT 27
`define SDCR_PWD_BIT 26
`define SDCR_FREQ_MSB 25
`define SDCR_FREQ_LSB 24
`define SDCR_RELOAD_MSB 23
`define SDCR_RELOAD_LSB 8
`define SDCR_ORG_MSB 7
`define SDCR_ORG_LSB 4
`define SDCR_ARE_MSB 3
`define SDCR_ARE_LSB 2
`define SDCR_RSV1_BIT 1
`define SDCR_SELF_BIT 0
`define SDCR_STAT_OFFSET 8'h24
`define SDCR_RELOAD_RST 16'h6188
`define SDCR_FREQ_RST 2'h0
`define SDCR_ORG_RST 4'h0
`define SDCR_UPORG_RST 2'h0
`define SDCR_ARE_RST 2'h0
`define SDCR_BURST_FOUR 4'h4
`define SDCR_BURST_EIGHT 4'h8
`define SDCR_BURST_ONE 4'h1
`endif

// >>> rtl/sdcr_pkg.sv
// Types of the SDRAM configuration and refresh block.
// Assumes nothing beyond the constants header.
package sdcr_pkg;
    typedef enum logic [1:0] {
        SDCR_FREQ_ZERO = 2'h0,
        SDCR_FREQ_ONE = 2'h1,
        SDCR_FREQ_TWO = 2'h2,
        SDCR_FREQ_THREE = 2'h3
    } sdcr_freq_t;
    typedef enum logic [1:0] {
        SDCR_ARE_OFF = 2'h0,
        SDCR_ARE_SINGLE = 2'h1,
        SDCR_ARE_BURST4 = 2'h2,
        SDCR_ARE_BURST8 = 2'h3
    } sdcr_are_t;
    typedef enum logic [1:0] {
        SDCR_SR_IDLE = 2'h0,
        SDCR_SR_ACTIVE = 2'h1,
        SDCR_SR_EXIT = 2'h3
    } sdcr_sr_t;
    typedef struct packed {
        logic [3:0] bank_count;
        logic [1:0] device_count;
        logic [7:0] size_mbyte;
        logic [4:0] data_width;
        logic valid;
    } sdcr_geom_t;
endpackage

// >>> rtl/sdcr_refresh.sv
// Refresh interval counter and burst queue.
// Assumes reload and mode are stable register outputs on the same clock.
`timescale 1ns/1ps
`include "sdcr_consts.svh"
module sdcr_refresh
    import sdcr_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Configuration
    input wire logic [15:0] reload_i,
    input wire sdcr_are_t mode_i,
    // Refresh handshake and status
    output logic refresh_request_o,
    input wire logic refresh_ack_i,
    output logic [15:0] count_o,
    output logic [3:0] pending_o
);
    logic [15:0] count;
    logic [15:0] next_count;
    logic [3:0] pending;
    logic [3:0] next_pending;
    logic [3:0] burst_len;
    logic expire;
    logic take;

    always_comb begin
        unique case (mode_i)
            SDCR_ARE_SINGLE: burst_len = `SDCR_BURST_ONE;
            SDCR_ARE_BURST4: burst_len = `SDCR_BURST_FOUR;
            SDCR_ARE_BURST8: burst_len = `SDCR_BURST_EIGHT;
            default: burst_len = 4'h0;
        endcase
    end

    assign expire = (mode_i != SDCR_ARE_OFF) && (count == 16'h0000);
    assign take = refresh_request_o && refresh_ack_i;

    always_comb begin
        next_count = count;
        next_pending = pending;
        if (mode_i == SDCR_ARE_OFF) begin
            // Disabled: drop the queue, the processor refreshes itself
            next_count = reload_i;
            next_pending = 4'h0;
        end else begin
            if (expire) begin
                next_count = reload_i;
            end else begin
                next_count = count - 16'h0001;
            end
            if (take) begin
                next_pending = pending - 4'h1;
            end
            // Queue saturates: a late ack must not wrap the counter
            if (expire) begin
                if ((5'(next_pending) + 5'(burst_len)) > 5'h0f) begin
                    next_pending = 4'hf;
                end else begin
                    next_pending = next_pending + burst_len;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count <= `SDCR_RELOAD_RST;
            pending <= 4'h0;
        end else begin
            count <= next_count;
            pending <= next_pending;
        end
    end

    assign refresh_request_o = (pending != 4'h0);
    assign count_o = count;
    assign pending_o = pending;
endmodule

// >>> rtl/sdcr_geometry.sv
// Decoder from six-bit organization code to device geometry.
// Assumes a registered code; output is purely combinational.
`timescale 1ns/1ps
module sdcr_geometry
    import sdcr_pkg::*;
(
    // Organization code
    input wire logic [5:0] code_i,
    // Decoded geometry
    output sdcr_geom_t geom_o
);
    always_comb begin
        geom_o = '{bank_count: 4'h0, device_count: 2'h0, size_mbyte: 8'h00,
                   data_width: 5'h00, valid: 1'b0};
        unique case (code_i)
            6'h00: geom_o = '{4'h2, 2'h2, 8'h04, 5'h08, 1'b1};
            6'h02: geom_o = '{4'h2, 2'h1, 8'h02, 5'h10, 1'b1};
            6'h04: geom_o = '{4'h2, 2'h2, 8'h10, 5'h08, 1'b1};
            6'h06: geom_o = '{4'h2, 2'h1, 8'h08, 5'h10, 1'b1};
            6'h05: geom_o = '{4'h4, 2'h2, 8'h10, 5'h08, 1'b1};
            6'h07: geom_o = '{4'h4, 2'h1, 8'h08, 5'h10, 1'b1};
            6'h09: geom_o = '{4'h4, 2'h2, 8'h20, 5'h08, 1'b1};
            6'h0b: geom_o = '{4'h4, 2'h1, 8'h10, 5'h10, 1'b1};
            6'h0d: geom_o = '{4'h4, 2'h2, 8'h40, 5'h08, 1'b1};
            6'h0f: geom_o = '{4'h4, 2'h1, 8'h20, 5'h10, 1'b1};
            6'h10: geom_o = '{4'h4, 2'h2, 8'h80, 5'h08, 1'b1};
            6'h20: geom_o = '{4'h4, 2'h1, 8'h80, 5'h10, 1'b1};
            default: geom_o.valid = 1'b0;
        endcase
    end
endmodule

// >>> rtl/sdcr_top.sv
// Configuration register, refresh control and self-refresh request for an SDRAM port.
// Assumes a classic Wishbone master on clk_i and an SDRAM sequencer that acks refreshes.
`timescale 1ns/1ps
`include "sdcr_consts.svh"
module sdcr_top
    import sdcr_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Sequencer side
    output logic refresh_request_o,
    input wire logic refresh_ack_i,
    input wire logic sdram_access_i,
    input wire logic self_refresh_exit_i,
    output logic self_refresh_request_o,
    // Configuration outputs
    output logic [1:0] freq_range_o,
    output logic [5:0] org_code_o,
    output logic [3:0] bank_count_o,
    output logic [1:0] device_count_o,
    output logic [7:0] size_mbyte_o,
    output logic [4:0] data_width_o,
    output logic org_valid_o,
    output logic power_down_en_o,
    output logic sdram_clk_en_o
);
    logic [1:0] up_org;
    logic [1:0] next_up_org;
    logic clk_dis;
    logic next_clk_dis;
    logic pwd;
    logic next_pwd;
    sdcr_freq_t freq;
    sdcr_freq_t next_freq;
    logic [15:0] reload;
    logic [15:0] next_reload;
    logic [3:0] org;
    logic [3:0] next_org;
    sdcr_are_t are;
    sdcr_are_t next_are;
    logic self_req;
    logic next_self_req;
    logic ack;
    logic next_ack;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    sdcr_sr_t sr_state;
    sdcr_sr_t next_sr_state;
    logic acc_s1;
    logic acc_s2;
    logic exit_s1;
    logic exit_s2;
    logic [15:0] rf_count;
    logic [3:0] rf_pending;
    logic [31:0] cfg_word;
    logic [31:0] wmask;
    logic [31:0] wval;
    logic wr;
    logic rd_pulse;
    sdcr_geom_t geom;

    // Byte lane mask; sel bits pick the lanes that take write data
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign wmask[gi*8 +: 8] = {8{wb_sel_i[gi]}};
        end
    endgenerate

    // Self-refresh handshake lines come from the memory side, so sync them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_s1 <= 1'b0;
            acc_s2 <= 1'b0;
            exit_s1 <= 1'b0;
            exit_s2 <= 1'b0;
        end else begin
            acc_s1 <= sdram_access_i;
            acc_s2 <= acc_s1;
            exit_s1 <= self_refresh_exit_i;
            exit_s2 <= exit_s1;
        end
    end

    always_comb begin
        cfg_word = 32'h0000_0000;
        cfg_word[`SDCR_UPORG_MSB:`SDCR_UPORG_LSB] = up_org;
        cfg_word[`SDCR_CLKDIS_BIT] = clk_dis;
        cfg_word[`SDCR_PWD_BIT] = pwd;
        cfg_word[`SDCR_FREQ_MSB:`SDCR_FREQ_LSB] = freq;
        cfg_word[`SDCR_RELOAD_MSB:`SDCR_RELOAD_LSB] = reload;
        cfg_word[`SDCR_ORG_MSB:`SDCR_ORG_LSB] = org;
        cfg_word[`SDCR_ARE_MSB:`SDCR_ARE_LSB] = are;
        cfg_word[`SDCR_RSV1_BIT] = 1'b1;
        cfg_word[`SDCR_SELF_BIT] = self_req;
    end

    // One wait state: ack in the cycle after the request, dropped next cycle
    // Write lands on the acknowledged edge, while the request still stands
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack;
    assign rd_pulse = wb_cyc_i && wb_stb_i && !wb_we_i && !ack;
    assign wval = (cfg_word & ~wmask) | (wb_dat_i & wmask);

    always_comb begin
        next_ack = wb_cyc_i && wb_stb_i && !ack;
        next_rdata = rdata;
        next_up_org = up_org;
        next_clk_dis = clk_dis;
        next_pwd = pwd;
        next_freq = freq;
        next_reload = reload;
        next_org = org;
        next_are = are;
        next_self_req = self_req;
        if (rd_pulse) begin
            unique case (wb_adr_i)
                `SDCR_CFG_OFFSET: next_rdata = cfg_word;
                `SDCR_STAT_OFFSET: next_rdata = {8'h00, rf_pending, 2'(sr_state),
                                                 1'b0, refresh_request_o, rf_count};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
        if (wr && wb_adr_i == `SDCR_CFG_OFFSET) begin
            next_up_org = wval[`SDCR_UPORG_MSB:`SDCR_UPORG_LSB];
            next_clk_dis = wval[`SDCR_CLKDIS_BIT];
            next_pwd = wval[`SDCR_PWD_BIT];
            next_freq = sdcr_freq_t'(wval[`SDCR_FREQ_MSB:`SDCR_FREQ_LSB]);
            next_reload = wval[`SDCR_RELOAD_MSB:`SDCR_RELOAD_LSB];
            next_org = wval[`SDCR_ORG_MSB:`SDCR_ORG_LSB];
            next_are = sdcr_are_t'(wval[`SDCR_ARE_MSB:`SDCR_ARE_LSB]);
            next_self_req = wval[`SDCR_SELF_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack <= 1'b0;
            rdata <= 32'h0000_0000;
            up_org <= `SDCR_UPORG_RST;
            clk_dis <= 1'b0;
            pwd <= 1'b0;
            freq <= SDCR_FREQ_ZERO;
            reload <= `SDCR_RELOAD_RST;
            org <= `SDCR_ORG_RST;
            are <= SDCR_ARE_OFF;
            self_req <= 1'b0;
        end else begin
            ack <= next_ack;
            rdata <= next_rdata;
            up_org <= next_up_org;
            clk_dis <= next_clk_dis;
            pwd <= next_pwd;
            freq <= next_freq;
            reload <= next_reload;
            org <= next_org;
            are <= next_are;
            self_req <= next_self_req;
        end
    end

    // Self-refresh tracker: after the memory leaves self-refresh on its own,
    // the next access sends it back while the bit stays set
    always_comb begin
        next_sr_state = sr_state;
        unique case (sr_state)
            SDCR_SR_IDLE: begin
                if (self_req) begin
                    next_sr_state = SDCR_SR_ACTIVE;
                end
            end
            SDCR_SR_ACTIVE: begin
                if (!self_req) begin
                    next_sr_state = SDCR_SR_IDLE;
                end else if (exit_s2) begin
                    next_sr_state = SDCR_SR_EXIT;
                end
            end
            SDCR_SR_EXIT: begin
                if (!self_req) begin
                    next_sr_state = SDCR_SR_IDLE;
                end else if (acc_s2) begin
                    next_sr_state = SDCR_SR_ACTIVE;
                end
            end
            default: next_sr_state = SDCR_SR_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sr_state <= SDCR_SR_IDLE;
        end else begin
            sr_state <= next_sr_state;
        end
    end

    assign self_refresh_request_o = (sr_state == SDCR_SR_ACTIVE);

    sdcr_refresh u_refresh (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .reload_i(reload),
        .mode_i(are),
        .refresh_request_o(refresh_request_o),
        .refresh_ack_i(refresh_ack_i),
        .count_o(rf_count),
        .pending_o(rf_pending)
    );

    sdcr_geometry u_geometry (
        .code_i({up_org, org}),
        .geom_o(geom)
    );

    assign wb_ack_o = ack;
    assign wb_dat_o = rdata;
    assign freq_range_o = freq;
    assign org_code_o = {up_org, org};
    assign bank_count_o = geom.bank_count;
    assign device_count_o = geom.device_count;
    assign size_mbyte_o = geom.size_mbyte;
    assign data_width_o = geom.data_width;
    assign org_valid_o = geom.valid;
    assign power_down_en_o = pwd;
    assign sdram_clk_en_o = !clk_dis;
endmodule

// >>> tb/sdcr_checker.sv
// Port checker for the SDRAM configuration block.
// Assumes one clock clk_i and a synchronous reset rst_i.
`timescale 1ns/1ps
module sdcr_checker (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Outputs watched
    input wire logic refresh_request_o,
    input wire logic [1:0] freq_range_o,
    input wire logic [5:0] org_code_o,
    input wire logic sdram_clk_en_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic wr;
    assign wr = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 8'h20;
    AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_FREQ: assert property (wr && wb_sel_i[3] |=> freq_range_o == $past(wb_dat_i[25:24]))
        else $error("frequency range not taken from write");
    AST_CLK: assert property (wr && wb_sel_i[3] |=> sdram_clk_en_o == !$past(wb_dat_i[27]))
        else $error("clock enable not inverse of disable bit");
    AST_ORG: assert property (wr && wb_sel_i[0] && wb_sel_i[3] |=>
        org_code_o == {$past(wb_dat_i[29:28]), $past(wb_dat_i[7:4])})
        else $error("organization code not taken from write");
    AST_RSV: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h20 |->
        wb_dat_o[1] && wb_dat_o[31:30] == 2'h0) else $error("fixed bits read wrong");
    AST_RST: assert property ($fell(rst_i) |-> freq_range_o == 2'h0 &&
        org_code_o == 6'h00 && sdram_clk_en_o && !refresh_request_o)
        else $error("outputs not at reset values");
    AST_OFF: assert property (wr && wb_sel_i[0] && wb_dat_i[3:2] == 2'h0 |->
        ##2 !refresh_request_o) else $error("refresh request survives disable");
endmodule
bind sdcr_top sdcr_checker u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .refresh_request_o,
    .freq_range_o, .org_code_o, .sdram_clk_en_o);

// >>> tb/sdcr_seq_model.sv
// Sequencer stand-in that takes refresh requests.
// Assumes the bench gates it with ack_en_i.
`timescale 1ns/1ps
module sdcr_seq_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic ack_en_i,
    input wire logic refresh_request_i,
    output logic refresh_ack_o
);
    logic next_ack;
    always_comb begin
        // Every other cycle, so bursts are taken slowly
        next_ack = ack_en_i && refresh_request_i && !refresh_ack_o;
    end
    always_ff @(posedge clk_i) begin
        refresh_ack_o <= rst_i ? 1'b0 : next_ack;
    end
endmodule

// >>> tb/tb_top.sv
// Directed bench for the SDRAM configuration block.
// Assumes the sequencer stand-in and the bound port checker.
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o, rd;
    logic wb_ack_o, refresh_request_o, refresh_ack_i, self_refresh_request_o;
    logic [1:0] freq_range_o, device_count_o;
    logic [5:0] org_code_o;
    logic [3:0] bank_count_o;
    logic [7:0] size_mbyte_o;
    logic [4:0] data_width_o;
    logic org_valid_o, power_down_en_o, sdram_clk_en_o;
    logic ack_en = 1'b0;
    logic sdram_access_i = 1'b0;
    logic self_refresh_exit_i = 1'b0;
    int fail_count = 0;
    int check_count = 0;
    int n;
    int s;
    // Reload 0x1e keeps the refresh period short
    localparam logic [31:0] BC = 32'h0000_1e02;
    always #2 clk_i = ~clk_i;
    sdcr_top dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .refresh_request_o, .refresh_ack_i,
        .sdram_access_i, .self_refresh_exit_i, .self_refresh_request_o, .freq_range_o,
        .org_code_o, .bank_count_o, .device_count_o, .size_mbyte_o, .data_width_o,
        .org_valid_o, .power_down_en_o, .sdram_clk_en_o);
    sdcr_seq_model seq (.clk_i, .rst_i, .ack_en_i(ack_en),
        .refresh_request_i(refresh_request_o), .refresh_ack_o(refresh_ack_i));
    task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hf;
        wb_dat_i <= d;
        rd = 'x;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic tk(input int k);
        repeat (k) @(posedge clk_i);
    endtask
    task automatic wait_req();
        int i;
        for (i = 0; i < 200; i++) begin
            @(posedge clk_i);
            if (refresh_request_o === 1'b1) break;
        end
        if (i == 200) begin
            fail_count++;
            $display("unexpected refresh request expected 1 seen 0");
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        conclude();
    end
    initial begin
        tk(10);
        rst_i <= 1'b0;
        wb(1'b0, 8'h20, 0);
        ck("reset word", 32'h0061_8802, rd);
        wb(1'b1, 8'h20, 32'hffff_ffff);
        wb(1'b1, 8'h40, 0);
        wb(1'b0, 8'h20, 0);
        ck("ones word", 32'h3fff_ffff, rd);
        ck("clock gated", 0, sdram_clk_en_o);
        ck("power down", 1, power_down_en_o);
        wb(1'b0, 8'h40, 0);
        ck("unmapped", 0, rd);
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            wb(1'b1, 8'h20, BC | (i << 4) | ((i % 4) << 24));
            tk(1);
            ck("freq", i % 4, freq_range_o);
            ck("org", i, org_code_o);
            ck("valid", (i == 1 || i == 3) ? 0 : 1, org_valid_o);
            if (i == 1 || i == 3) continue;
            ck("devices", i[1] ? 1 : 2, device_count_o);
            ck("width", i[1] ? 16 : 8, data_width_o);
            ck("banks", i[0] ? 4 : 2, bank_count_o);
            ck("mbyte", (i[2] ? 16 : 4) >> i[1], size_mbyte_o);
        end
        wb(1'b1, 8'h20, BC | 32'h2000_0000);
        tk(1);
        ck("upper org", 32, org_code_o);
        ck("upper mbyte", 128, size_mbyte_o);
        $display("test geometry done");
        for (int m = 1; m < 4; m++) begin
            ack_en <= 1'b0;
            wb(1'b1, 8'h20, BC);
            wb(1'b1, 8'h20, BC | (m << 2));
            wait_req();
            ack_en <= 1'b1;
            n = 0;
            repeat (24) begin
                @(posedge clk_i);
                if ((refresh_request_o & refresh_ack_i) === 1'b1) n++;
            end
            ck("burst", m == 1 ? 1 : m == 2 ? 4 : 8, n);
            ck("queue empty", 0, refresh_request_o);
        end
        ack_en <= 1'b0;
        wait_req();
        wb(1'b1, 8'h20, BC);
        tk(2);
        ck("off clears", 0, refresh_request_o);
        wb(1'b0, 8'h24, 0);
        ck("status", 32'h0000_001e, rd);
        ack_en <= 1'b1;
        wb(1'b1, 8'h20, BC | 4);
        wait_req();
        n = 0;
        s = 0;
        for (int k = 0; k < 100; k++) begin
            @(posedge clk_i);
            n++;
            if (refresh_request_o === 1'b0) s = 1;
            if (s != 0 && refresh_request_o === 1'b1) break;
        end
        ck("period", 32'h1e + 1, n);
        $display("test refresh done");
        wb(1'b1, 8'h20, BC | 1);
        tk(3);
        ck("self enter", 1, self_refresh_request_o);
        self_refresh_exit_i <= 1'b1;
        tk(6);
        ck("self exit", 0, self_refresh_request_o);
        self_refresh_exit_i <= 1'b0;
        sdram_access_i <= 1'b1;
        tk(6);
        ck("self return", 1, self_refresh_request_o);
        sdram_access_i <= 1'b0;
        wb(1'b1, 8'h20, BC);
        tk(3);
        ck("self off", 0, self_refresh_request_o);
        $display("test self refresh done");
        conclude();
    end
endmodule
